// ---- led_meter_display_scanner_test.sv ----
`timescale 1ns/1ns
module led_meter_display_scanner_test
   import lmd_pkg::*;
;
   localparam int ON       = 160;
   localparam int UPD      = 1000;
   localparam int REFW     = 4000;
   localparam int CALW     = 200;
   localparam int SETTLE   = 2700;
   localparam int PL35 [4] = '{1, 2, 0, 3};

   logic SYS_CLK_I, RST_I, HOLD_I, PEAK_I, POINT_ENABLE_I;
   logic POINT_SELECT_HI_I, POINT_SELECT_LO_I, DISPLAY_ENABLE_I;
   logic INTERNAL_REF_SELECT_I, RANGE_SELECT_I, REF_VALID_I;
   logic RESULT_OVER_I, RESULT_UNDER_I, RESULT_VALID_I;
   logic FILTER_RESET_O, CALIBRATING_O, CONVERT_ENABLE_O, OFFSET_CAL_O;
   logic REF_INTERNAL_O, RANGE_NARROW_O, SEGMENT_POINT_OUT_O, oc3, pt3;
   logic signed [CNT_W-1:0] REF_LEVEL_I, RESULT_I;
   logic [6:0]              SEGMENT_OUT_O, seg3;
   logic [4:0]              DIGIT_OUT_O, dig3;
   logic [39:0]             fr45, fr35;
   logic [80:0]             notes [$];
   int                      viol45, viol35, err_count, check_count;
   int                      seed, t0, i, k;
   int                      cyc = 0;
   int                      tab [8][4] = '{'{1, 0, 500, 500},
      '{1, 0, 300, 500}, '{1, 0, 800, 800}, '{0, 0, 100, 100},
      '{1, 0, 50, 50}, '{1, 1, 900, 50}, '{1, 0, 20, 900},
      '{0, 0, -1234, -1234}};
   event                    snap;

   lmd_scanner #(.VARIANT_45(1'b1), .ON_CYC(ON), .UPD_CYC(UPD),
      .REF_CYC(REFW), .CALIB_CYC(CALW)) dut (.*);
   lmd_scanner #(.VARIANT_45(1'b0), .ON_CYC(ON), .UPD_CYC(UPD),
      .REF_CYC(REFW), .CALIB_CYC(CALW)) dut35 (.*, .FILTER_RESET_O(),
      .CALIBRATING_O(), .CONVERT_ENABLE_O(), .OFFSET_CAL_O(oc3),
      .REF_INTERNAL_O(), .RANGE_NARROW_O(), .SEGMENT_OUT_O(seg3),
      .SEGMENT_POINT_OUT_O(pt3), .DIGIT_OUT_O(dig3));
   lmd_disp_model #(.NDIG(5), .ON(ON)) disp45 (.clk_i(SYS_CLK_I),
      .seg_i(SEGMENT_OUT_O), .point_i(SEGMENT_POINT_OUT_O),
      .digit_i(DIGIT_OUT_O), .frame_o(fr45), .viol_o(viol45));
   lmd_disp_model #(.NDIG(4), .ON(ON)) disp35 (.clk_i(SYS_CLK_I),
      .seg_i(seg3), .point_i(pt3), .digit_i(dig3), .frame_o(fr35),
      .viol_o(viol35));

   // **********
   // helpers
   // **********
   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge SYS_CLK_I);
      #1;
   endtask : tick

   function automatic logic [39:0] fmt(input int v, input bit ov,
                                       input bit un, input int p,
                                       input int nd);
      logic [39:0] f;
      int          m, d, j;
      bit          lead;
      f = 40'h0;
      m = (v < 0) ? -v : v;
      lead = m < 10 ** (nd - 1);
      if (ov || un) return {32'h0, SEG_ONE | (un ? SEG_MINUS : 8'h00)};
      f[7:0] = (lead ? 8'h00 : SEG_ONE) | ((v < 0) ? SEG_MINUS : 8'h00);
      for (j = nd - 2; j >= 0; j--) begin
         d = (m / 10 ** j) % 10;
         if (!(lead && d == 0 && j > p)) begin
            lead = 1'b0;
            f[8*(nd-1-j) +: 8] = SEG_NUM[d];
         end
      end
      if (p > 0) f[8*(nd-1-p)+7] = 1'b1;
      return f;
   endfunction : fmt

   // one result strobe, then count the calibration pulses of each variant
   task automatic strobe(input int v, input bit ov, input bit un,
                         input logic [7:0] e45, input logic [7:0] e35);
      logic [7:0] n45, n35;
      n45 = 8'h00;
      n35 = 8'h00;
      RESULT_I = v[15:0];
      {RESULT_OVER_I, RESULT_UNDER_I} = {ov, un};
      RESULT_VALID_I = 1'b1;
      tick(1);
      RESULT_VALID_I = 1'b0;
      repeat (3) begin
         n45 = n45 + OFFSET_CAL_O;
         n35 = n35 + oc3;
         tick(1);
      end
      chk({n45, n35}, {e45, e35});
   endtask : strobe

   task automatic show(input int v, input bit ov, input bit un,
                       input bit use35);
      int p45, p35;
      p45 = POINT_ENABLE_I ? {POINT_SELECT_HI_I, POINT_SELECT_LO_I} + 1 : 0;
      p35 = PL35[{POINT_SELECT_HI_I, POINT_SELECT_LO_I}];
      notes.push_back({use35, fmt(v, ov, un, p45, 5),
                       fmt(v, ov, un, p35, 4)});
      tick(SETTLE);
      -> snap;
   endtask : show

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   // **********
   // clock, watchdog, result watcher
   // **********
   initial begin
      SYS_CLK_I = 1'b0;
      forever #20 SYS_CLK_I = ~SYS_CLK_I;
   end

   always @(posedge SYS_CLK_I) cyc++;

   initial begin
      repeat (100000) @(posedge SYS_CLK_I);
      err_count++;
      test_done();
   end

   initial begin
      logic [80:0] n;
      forever begin
         @(snap);
         n = notes.pop_front();
         chk({fr45, n[80] ? fr35 : n[39:0]}, n[79:0]);
      end
   end

   // **********
   // main sequence
   // **********
   initial begin
      seed = 84;
      err_count = 0;
      check_count = 0;
      RST_I = 1'b1;
      {HOLD_I, PEAK_I, POINT_ENABLE_I} = 3'h0;
      {POINT_SELECT_HI_I, POINT_SELECT_LO_I} = 2'h2;
      {DISPLAY_ENABLE_I, INTERNAL_REF_SELECT_I} = 2'h3;
      {RANGE_SELECT_I, REF_VALID_I, RESULT_VALID_I} = 3'h0;
      {RESULT_OVER_I, RESULT_UNDER_I} = 2'h0;
      REF_LEVEL_I = 16'h04d2;
      RESULT_I = 16'h0000;
      tick(10);
      chk(FILTER_RESET_O, 1'b1);
      RST_I = 1'b0;
      t0 = cyc;
      tick(8);
      chk({FILTER_RESET_O, CONVERT_ENABLE_O}, 2'h2);
      tick(10);
      chk({FILTER_RESET_O, CALIBRATING_O, CONVERT_ENABLE_O}, 3'h0);
      strobe(5, 1'b0, 1'b0, 8'h00, 8'h01);
      show(1234, 1'b0, 1'b0, 1'b0);
      while (CALIBRATING_O !== 1'b1 && cyc - t0 < 2 * REFW) tick(1);
      chk(cyc - t0 >= 16 + REFW && cyc - t0 <= 22 + REFW, 1'b1);
      t0 = cyc;
      while (CONVERT_ENABLE_O !== 1'b1 && cyc - t0 < 2 * CALW) tick(1);
      chk({cyc - t0, CALIBRATING_O}, {CALW, 1'b0});
      for (i = 0; i < 4; i++) begin
         {INTERNAL_REF_SELECT_I, RANGE_SELECT_I} = i[1:0];
         tick(4);
         chk({REF_INTERNAL_O, RANGE_NARROW_O}, i[1:0]);
      end
      $display("test power-up done");
      for (k = 0; k < 16; k++) begin
         {POINT_ENABLE_I, POINT_SELECT_HI_I, POINT_SELECT_LO_I} = k[3:1];
         i = k[0] ? $random(seed) % 2000 : 0;
         strobe(i, 1'b0, 1'b0, 8'h01, 8'h01);
         show(i, 1'b0, 1'b0, 1'b1);
      end
      $display("test point and zero suppression done");
      {POINT_ENABLE_I, POINT_SELECT_HI_I, POINT_SELECT_LO_I} = 3'h2;
      strobe(100, 1'b1, 1'b0, 8'h01, 8'h01);
      show(0, 1'b1, 1'b0, 1'b1);
      strobe(-100, 1'b0, 1'b1, 8'h01, 8'h01);
      show(0, 1'b0, 1'b1, 1'b1);
      $display("test range limits done");
      for (k = 0; k < 8; k++) begin
         PEAK_I = (tab[k][0] != 0);
         HOLD_I = (tab[k][1] != 0);
         tick(4);
         strobe(tab[k][2], 1'b0, 1'b0, 8'h01, 8'h01);
         show(tab[k][3], 1'b0, 1'b0, 1'b1);
      end
      $display("test peak and hold done");
      DISPLAY_ENABLE_I = 1'b0;
      tick(4);
      k = 0;
      repeat (1000) begin
         tick(1);
         if ({SEGMENT_OUT_O, SEGMENT_POINT_OUT_O, DIGIT_OUT_O, seg3, pt3,
              dig3} !== 26'h0) k++;
      end
      chk(k, 0);
      DISPLAY_ENABLE_I = 1'b1;
      chk({viol45, viol35}, 64'h0);
      $display("test display scan done");
      REF_VALID_I = 1'b1;
      RST_I = 1'b1;
      tick(2);
      RST_I = 1'b0;
      t0 = cyc;
      while (CALIBRATING_O !== 1'b1 && cyc - t0 < 100) tick(1);
      chk(cyc - t0 <= 24, 1'b1);
      $display("test early reference done");
      test_done();
   end
endmodule : led_meter_display_scanner_test

// ---- lmd_disp_model.sv ----
`timescale 1ns/1ns
// **********
// passive common-cathode display, records what each digit shows
// **********
module lmd_disp_model
   import lmd_pkg::*;
#(
   parameter int NDIG = 5,
   parameter int ON   = 160
) (
   // driver pins
   input  wire logic       clk_i,
   input  wire logic [6:0] seg_i,
   input  wire logic       point_i,
   input  wire logic [4:0] digit_i,
   // what a viewer sees
   output logic [39:0]     frame_o,
   output int              viol_o
);
   logic [4:0] prev = 5'h00;
   int         idx;
   int         k;
   int         last = -1;
   int         gap  = 0;
   int         per  = -1;

   initial begin
      frame_o = 40'h0;
      viol_o  = 0;
   end

   always @(posedge clk_i) begin
      if (digit_i == 5'h00 || $isunknown(digit_i)) begin
         gap++;
         if ({point_i, seg_i} != 8'h00) viol_o++;
      end else begin
         if ($countones(digit_i) != 1) viol_o++;
         if (prev == 5'h00) begin
            idx = 0;
            for (k = 0; k < 5; k++) if (digit_i[k]) idx = k;
            // a long dark spell means the display was off
            if (gap >= ON) per = -1;
            else if (last >= 0 && (gap < BLANK_CYC ||
                     idx != (last + 1) % NDIG)) viol_o++;
            if (idx == 0 && per >= 0 && per != NDIG * ON) viol_o++;
            if (idx == 0) per = 0;
            frame_o[8*idx +: 8] = {point_i, seg_i};
            last = idx;
         end else if (digit_i != prev) viol_o++;
         gap = 0;
      end
      if (per >= 0) per++;
      prev = digit_i;
   end
endmodule : lmd_disp_model

// ---- lmd_pkg.sv ----
package lmd_pkg;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_HZ        = 25_000_000;
   localparam int CLK_NS        = 40;
   localparam int CLK_KHZ       = CLK_HZ / 1000;
   localparam int SCAN_NS_45    = 1_953_120;
   localparam int SCAN_NS_35    = 1_562_500;
   localparam int DIG_ON_NS     = 390_600;
   localparam int DIG_ON_CYC    = DIG_ON_NS / CLK_NS;
   localparam int BLANK_NS      = 4_000;
   localparam int BLANK_CYC     = (BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int UPDATE_MHZ    = 2_500;
   localparam int UPDATE_CYC    = (CLK_HZ / UPDATE_MHZ) * 1000;
   localparam int REF_WAIT_MS   = 6_000;
   localparam int REF_WAIT_CYC  = REF_WAIT_MS * CLK_KHZ;
   localparam int CAL_MS        = 2_000;
   localparam int CAL_CYC       = CAL_MS * CLK_KHZ;
   localparam int FRESET_CYC    = 16;

   // ***************************************************
   // widths and pin indices of the synchroniser bank
   // ***************************************************
   localparam int CNT_W   = 16;
   localparam int TMR_W   = 28;
   localparam int SLOT_W  = 14;
   localparam int PIN_N   = 9;
   localparam int P_HOLD  = 0;
   localparam int P_PEAK  = 1;
   localparam int P_PEN   = 2;
   localparam int P_PHI   = 3;
   localparam int P_PLO   = 4;
   localparam int P_DEN   = 5;
   localparam int P_REFS  = 6;
   localparam int P_RNG   = 7;
   localparam int P_REFOK = 8;

   // ***************************************************
   // segment patterns, bit order {dp,g,f,e,d,c,b,a}
   // ***************************************************
   localparam logic [7:0] SEG_NUM [10] = '{8'h3f, 8'h06, 8'h5b, 8'h4f,
      8'h66, 8'h6d, 8'h7d, 8'h07, 8'h7f, 8'h6f};
   localparam logic [7:0] SEG_ONE   = 8'h06;
   localparam logic [7:0] SEG_MINUS = 8'h40;
   localparam logic [7:0] SEG_POINT = 8'h80;

   typedef enum logic [1:0] {
      SEQ_FRESET  = 2'b00,
      SEQ_REFWAIT = 2'b01,
      SEQ_CAL     = 2'b10,
      SEQ_RUN     = 2'b11
   } lmd_seq_t;

endpackage : lmd_pkg

// ---- lmd_scanner.sv ----
`timescale 1ns/1ns
// Function
// - hold shows held value, else peak shows peak, else latest result
// - displayed value is refreshed at 2.5 Hz
// - only one digit cathode active; segments carry that digit's pattern
// - full scan repeats every 1.9531 ms (4.5 digit) or 1.5625 ms
// - each digit on one fifth or one quarter of scan, 390.6 us
// - segment, point and digit outputs blanked about 4 us between digits
// - 4.5 digit: point off unless enabled; select places point 1..4
// - 3.5 digit: select 00,01,10,11 gives one, two, none, three places
// - leading zeros left of the digit before the point are blanked
// - overrange shows lone 1, underrange shows minus and 1
// - segment outputs shared by all digits; one digit output per position
// - reference select high means internal, low external reference
// - range select low gives 2 V scale, high gives 200 mV scale
// - filter and modulator reset at power-up before any result
// - 4.5 digit waits up to 6 s for reference, showing its level
// - 4.5 digit calibrates offset about 2 s before conversions start
// - offset calibration requested within every conversion cycle
// - peak mode keeps value and replaces it only with larger results
// - peak input low clears stored peak and leaves peak mode
// - display enable low turns all driver outputs off
module lmd_scanner
   import lmd_pkg::*;
#(
   parameter bit VARIANT_45 = 1'b1,
   parameter int ON_CYC     = DIG_ON_CYC,
   parameter int UPD_CYC    = UPDATE_CYC,
   parameter int REF_CYC    = REF_WAIT_CYC,
   parameter int CALIB_CYC  = CAL_CYC
) (
   // clock and reset
   input  wire logic                    SYS_CLK_I,
   input  wire logic                    RST_I,
   // mode and format pins
   input  wire logic                    HOLD_I,
   input  wire logic                    PEAK_I,
   input  wire logic                    POINT_ENABLE_I,
   input  wire logic                    POINT_SELECT_HI_I,
   input  wire logic                    POINT_SELECT_LO_I,
   input  wire logic                    DISPLAY_ENABLE_I,
   input  wire logic                    INTERNAL_REF_SELECT_I,
   input  wire logic                    RANGE_SELECT_I,
   // from the converter core
   input  wire logic                    REF_VALID_I,
   input  wire logic signed [CNT_W-1:0] REF_LEVEL_I,
   input  wire logic signed [CNT_W-1:0] RESULT_I,
   input  wire logic                    RESULT_OVER_I,
   input  wire logic                    RESULT_UNDER_I,
   input  wire logic                    RESULT_VALID_I,
   // to the converter core
   output logic                         FILTER_RESET_O,
   output logic                         CALIBRATING_O,
   output logic                         CONVERT_ENABLE_O,
   output logic                         OFFSET_CAL_O,
   output logic                         REF_INTERNAL_O,
   output logic                         RANGE_NARROW_O,
   // display drivers
   output logic [6:0]                   SEGMENT_OUT_O,
   output logic                         SEGMENT_POINT_OUT_O,
   output logic [4:0]                   DIGIT_OUT_O
);

   localparam logic [2:0] NDIG = VARIANT_45 ? 3'd5 : 3'd4;

   typedef struct packed {
      logic [PIN_N-1:0]       sync1;
      logic [PIN_N-1:0]       sync2;
      logic                   hold_q;
      lmd_seq_t               seq;
      logic [TMR_W-1:0]       seq_tmr;
      logic signed [CNT_W-1:0] latest;
      logic [1:0]             latest_f;
      logic signed [CNT_W-1:0] held;
      logic [1:0]             held_f;
      logic signed [CNT_W-1:0] peak;
      logic [1:0]             peak_f;
      logic                   peak_valid;
      logic [TMR_W-1:0]       upd_tmr;
      logic                   upd_pend;
      logic [2:0]             dig;
      logic [SLOT_W-1:0]      slot_tmr;
      logic [4:0][7:0]        frame;
      logic [7:0]             seg;
      logic [4:0]             digit;
      logic                   freset;
      logic                   conv;
      logic                   cal;
      logic                   ocal;
   } lmd_state_t;

   lmd_state_t st;
   lmd_state_t next_st;

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [19:0] to_bcd(input logic [16:0] bin);
      logic [19:0] bcd;
      bcd = '0;
      for (int i = 16; i >= 0; i--) begin
         for (int n = 0; n < 5; n++) begin
            if (bcd[n*4 +: 4] > 4'd4) begin
               bcd[n*4 +: 4] = bcd[n*4 +: 4] + 4'd3;
            end
         end
         bcd = {bcd[18:0], bin[i]};
      end
      return bcd;
   endfunction : to_bcd

   // decimal places to the right of the point
   function automatic logic [2:0] dp_places(input logic en, input logic hi,
                                             input logic lo);
      if (VARIANT_45) begin
         return en ? {1'b0, hi, lo} + 3'd1 : 3'd0;
      end
      unique case ({hi, lo})
         2'b00:   return 3'd1;
         2'b01:   return 3'd2;
         2'b10:   return 3'd0;
         2'b11:   return 3'd3;
      endcase
   endfunction : dp_places

   // overrange ranks above every count, underrange below
   function automatic logic signed [CNT_W:0] rank(
      input logic signed [CNT_W-1:0] v, input logic [1:0] f);
      if (f[1]) begin
         return {2'b01, {(CNT_W-1){1'b1}}};
      end
      if (f[0]) begin
         return {2'b10, {(CNT_W-1){1'b0}}};
      end
      return {v[CNT_W-1], v};
   endfunction : rank

   function automatic logic [4:0][7:0] format(
      input logic signed [CNT_W-1:0] v, input logic [1:0] f,
      input logic [2:0] dp);
      logic [4:0][7:0] fr;
      logic [16:0]     mag;
      logic [19:0]     bcd;
      logic [3:0]      d;
      logic            lead;
      int              p;
      fr   = '0;
      mag  = v[CNT_W-1] ? 17'(-{v[CNT_W-1], v}) : 17'({1'b0, v});
      bcd  = to_bcd(mag);
      lead = 1'b1;
      for (int i = 0; i < 5; i++) begin
         p = int'(NDIG) - 1 - i;
         d = (p >= 0) ? bcd[p*4 +: 4] : 4'd0;
         if (p >= 0) begin
            if (lead && d == 4'd0 && p > int'(dp)) begin
               fr[i] = 8'h00;
            end else begin
               lead  = 1'b0;
               fr[i] = (i != 0) ? SEG_NUM[d] :
                       (d != 4'd0) ? SEG_ONE : 8'h00;
            end
            if (dp != 3'd0 && p == int'(dp)) begin
               fr[i] = fr[i] | SEG_POINT;
            end
         end
      end
      if (v[CNT_W-1]) begin
         fr[0] = fr[0] | SEG_MINUS;
      end
      if (f[1]) begin
         fr    = '0;
         fr[0] = SEG_ONE;
      end else if (f[0]) begin
         fr    = '0;
         fr[0] = SEG_ONE | SEG_MINUS;
      end
      return fr;
   endfunction : format

   // ***************************************************
   // next state
   // ***************************************************
   logic                    hold_s;
   logic                    peak_s;
   logic                    take;
   logic                    slot_end;
   logic                    scan_end;
   logic signed [CNT_W-1:0] shown;
   logic [1:0]              shown_f;

   assign hold_s   = st.sync2[P_HOLD];
   assign peak_s   = st.sync2[P_PEAK];
   assign take     = RESULT_VALID_I && st.conv;
   assign slot_end = st.slot_tmr == SLOT_W'(ON_CYC - 1);
   assign scan_end = slot_end && st.dig == NDIG - 3'd1;

   always_comb begin
      next_st       = st;
      next_st.sync1 = {REF_VALID_I, RANGE_SELECT_I, INTERNAL_REF_SELECT_I,
                       DISPLAY_ENABLE_I, POINT_SELECT_LO_I, POINT_SELECT_HI_I,
                       POINT_ENABLE_I, PEAK_I, HOLD_I};
      next_st.sync2 = st.sync1;
      next_st.hold_q = hold_s;

      // power-up sequence
      next_st.seq_tmr = st.seq_tmr + TMR_W'(1);
      unique case (st.seq)
         SEQ_FRESET: begin
            if (st.seq_tmr == TMR_W'(FRESET_CYC - 1)) begin
               next_st.seq     = VARIANT_45 ? SEQ_REFWAIT : SEQ_RUN;
               next_st.seq_tmr = '0;
            end
         end
         SEQ_REFWAIT: begin
            if (st.sync2[P_REFOK] ||
                st.seq_tmr == TMR_W'(REF_CYC - 1)) begin
               next_st.seq     = SEQ_CAL;
               next_st.seq_tmr = '0;
            end
         end
         SEQ_CAL: begin
            if (st.seq_tmr == TMR_W'(CALIB_CYC - 1)) begin
               next_st.seq     = SEQ_RUN;
               next_st.seq_tmr = '0;
            end
         end
         SEQ_RUN: begin
            next_st.seq_tmr = '0;
         end
      endcase
      next_st.freset = next_st.seq == SEQ_FRESET;
      next_st.cal    = next_st.seq == SEQ_CAL;
      next_st.conv   = next_st.seq == SEQ_RUN;
      next_st.ocal   = take;

      // value sources
      if (take) begin
         next_st.latest   = RESULT_I;
         next_st.latest_f = {RESULT_OVER_I, RESULT_UNDER_I};
      end
      if (!peak_s) begin
         next_st.peak_valid = 1'b0;
      end else if (take && (!st.peak_valid ||
               rank(RESULT_I, {RESULT_OVER_I, RESULT_UNDER_I}) >
               rank(st.peak, st.peak_f))) begin
         next_st.peak       = RESULT_I;
         next_st.peak_f     = {RESULT_OVER_I, RESULT_UNDER_I};
         next_st.peak_valid = 1'b1;
      end
      if (hold_s && !st.hold_q) begin
         next_st.held   = (peak_s && st.peak_valid) ? st.peak : st.latest;
         next_st.held_f = (peak_s && st.peak_valid) ? st.peak_f
                                                     : st.latest_f;
      end

      // selection by priority
      if (st.seq == SEQ_REFWAIT) begin
         shown   = REF_LEVEL_I;
         shown_f = 2'b00;
      end else if (hold_s) begin
         shown   = st.held;
         shown_f = st.held_f;
      end else if (peak_s && st.peak_valid) begin
         shown   = st.peak;
         shown_f = st.peak_f;
      end else begin
         shown   = st.latest;
         shown_f = st.latest_f;
      end

      // refresh tick, taken at the end of a full scan
      next_st.upd_tmr = st.upd_tmr + TMR_W'(1);
      next_st.upd_pend = st.upd_pend & ~scan_end;
      if (st.upd_tmr == TMR_W'(UPD_CYC - 1)) begin
         next_st.upd_tmr  = '0;
         next_st.upd_pend = 1'b1;
      end
      if (scan_end && st.upd_pend) begin
         next_st.frame = format(shown, shown_f,
            dp_places(st.sync2[P_PEN], st.sync2[P_PHI], st.sync2[P_PLO]));
      end

      // digit scan
      next_st.slot_tmr = st.slot_tmr + SLOT_W'(1);
      if (slot_end) begin
         next_st.slot_tmr = '0;
         next_st.dig = scan_end ? 3'd0 : st.dig + 3'd1;
      end
      if (st.sync2[P_DEN] &&
          st.slot_tmr >= SLOT_W'(BLANK_CYC)) begin
         next_st.digit = 5'(5'd1 << st.dig);
         next_st.seg   = st.frame[st.dig];
      end else begin
         next_st.digit = '0;
         next_st.seg   = '0;
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st        <= '0;
         st.seq    <= SEQ_FRESET;
         st.freset <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign FILTER_RESET_O      = st.freset;
   assign CALIBRATING_O       = st.cal;
   assign CONVERT_ENABLE_O    = st.conv;
   assign OFFSET_CAL_O        = st.ocal;
   assign REF_INTERNAL_O      = st.sync2[P_REFS];
   assign RANGE_NARROW_O      = st.sync2[P_RNG];
   assign SEGMENT_OUT_O       = st.seg[6:0];
   assign SEGMENT_POINT_OUT_O = st.seg[7];
   assign DIGIT_OUT_O         = st.digit;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   chk_one_digit: assert property ($onehot0(DIGIT_OUT_O))
      else $error("more than one digit active");
   chk_interdigit_blank: assert property (
      (DIGIT_OUT_O != 5'd0 && $past(DIGIT_OUT_O) != 5'd0)
      |-> DIGIT_OUT_O == $past(DIGIT_OUT_O))
      else $error("digit switched without blanking");
   chk_display_off: assert property (
      !st.sync2[P_DEN] |=> (DIGIT_OUT_O == 5'd0 && st.seg == 8'h00))
      else $error("display driven while disabled");
   chk_peak_clear: assert property (!peak_s |=> !st.peak_valid)
      else $error("peak kept after peak input low");
   chk_peak_rise: assert property (
      (peak_s && st.peak_valid && $past(st.peak_valid))
      |-> rank(st.peak, st.peak_f) >=
          rank($past(st.peak), $past(st.peak_f)))
      else $error("stored peak decreased");
   chk_no_conv_reset: assert property (
      FILTER_RESET_O |-> !CONVERT_ENABLE_O && !OFFSET_CAL_O)
      else $error("conversion during filter reset");
   chk_cal_span: assert property (
      $rose(CALIBRATING_O) |-> CALIBRATING_O [*8] ##1 !CONVERT_ENABLE_O)
      else $error("calibration cut short");
   chk_frame_bound: assert property (
      $changed(st.frame) |-> $past(scan_end))
      else $error("display value changed mid scan");
   chk_offset_cal: assert property ((take) |=> OFFSET_CAL_O)
      else $error("no offset calibration in conversion cycle");
   chk_hold_freeze: assert property (
      (hold_s && $past(hold_s) && $past(st.hold_q)) |-> $stable(st.held))
      else $error("held reading changed during hold");

   cov_hold: cover property ($rose(hold_s) ##[1:20] scan_end);
   cov_peak_update: cover property (take && peak_s && st.peak_valid
      ##1 $changed(st.peak));
   cov_over: cover property (scan_end && st.upd_pend && shown_f[1]);
   cov_run: cover property ($rose(CONVERT_ENABLE_O));

endmodule : lmd_scanner
